// ### include/tss_pkg.sv
`default_nettype none
package tss_pkg;
  // timing: one interval step is one millisecond
  localparam int CLK_NS = 10;
  localparam int STEP_NS = 1000000;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  // widths: 3600 s in ms fits 22 bits; repeat count up to 2**24
  localparam int LVL_W = 16;
  localparam int TIM_W = 22;
  localparam int REP_W = 25;
  localparam int ERR_W = TIM_W + LVL_W;
  localparam int NPH = 5;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_START = 8'h08;
  localparam logic [7:0] A_PEAK = 8'h0c;
  localparam logic [7:0] A_TIM0 = 8'h10;
  localparam logic [7:0] A_REP = 8'h24;
  localparam logic [7:0] A_DCV = 8'h28;
  localparam logic [7:0] A_DCI = 8'h2c;
  localparam logic [7:0] A_STEP = 8'h04;
  // control and status field positions
  localparam int B_TYPE = 0;
  localparam int B_HOLD = 1;
  localparam int B_CONT = 2;
  localparam int B_SRC = 3;
  localparam int B_MODE = 5;
  localparam int B_OUT = 6;
  localparam int B_RUN = 8;
  localparam int B_STOP = 9;
  localparam int B_BUSY = 3;
  // reset values
  localparam logic [REP_W-1:0] REP_RST = 25'h0000001;
  localparam logic CONT_RST = 1'b1;
  localparam logic [ERR_W-1:0] ERR_ZERO = 38'h0;
  typedef enum logic [1:0] {
    SRC_KEY = 2'b00,
    SRC_IO = 2'b01,
    SRC_RMT = 2'b10
  } tss_src_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_RISE = 3'b010,
    ST_PEAK = 3'b011,
    ST_FALL = 3'b100,
    ST_ENDH = 3'b101
  } tss_st_t;
  // raw front-panel and trigger pins
  typedef struct packed {
    logic run;
    logic stop;
    logic runstop;
    logic dtrig;
  } tss_keys_t;
  // local setpoint request from front-panel logic
  typedef struct packed {
    logic valid;
    logic is_curr;
    logic [LVL_W-1:0] value;
  } tss_set_req_t;
endpackage
`default_nettype wire

// ### rtl/tss_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module tss_ramp import tss_pkg::*; (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, low
  input wire logic load, // start a new ramp
  input wire logic tick, // one interval step
  input wire logic [LVL_W-1:0] from_lvl, // ramp start value
  input wire logic [LVL_W-1:0] to_lvl, // ramp end value
  input wire logic [TIM_W-1:0] len, // ramp length in steps
  output logic [LVL_W-1:0] level_ff // present ramp value
);
  logic up_ff;
  logic [LVL_W-1:0] mag_ff;
  logic [LVL_W-1:0] to_ff;
  logic [ERR_W-1:0] err_ff;
  logic step;
  logic [ERR_W-1:0] nxt_err;

  // error-accumulator line: no divider, one lsb per clock while owed;
  // steps stay linear as long as a tick spans more clocks than lsbs owed
  always_comb begin
    step = (err_ff >= ERR_W'(len)) && (len != '0) && (level_ff != to_ff);
    nxt_err = err_ff;
    if (tick) begin
      nxt_err = nxt_err + ERR_W'(mag_ff);
    end
    if (step) begin
      nxt_err = nxt_err - ERR_W'(len);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= '0;
      up_ff <= 1'b1;
      mag_ff <= '0;
      to_ff <= '0;
      err_ff <= ERR_ZERO;
    end else if (load) begin
      level_ff <= from_lvl;
      to_ff <= to_lvl;
      up_ff <= to_lvl >= from_lvl;
      mag_ff <= (to_lvl >= from_lvl) ? to_lvl - from_lvl
                                     : from_lvl - to_lvl;
      err_ff <= ERR_ZERO;
    end else begin
      err_ff <= nxt_err;
      if (step) begin
        level_ff <= up_ff ? level_ff + 1'b1 : level_ff - 1'b1;
      end
    end
  end
endmodule // tss_ramp
`default_nettype wire

// ### rtl/tss_top.sv
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - after a trigger, hold start level for the delay interval
// R2 - then ramp up from start level to peak over rise interval
// R3 - then hold the peak level for the peak width interval
// R4 - then ramp down from peak back to start over fall interval
// R5 - then hold start level for end interval, trapezoid done
// R6 - one start level serves before the rise and after the fall
// R7 - a separate peak level drives the top, any value in range
// R8 - type bit picks voltage or current target, voltage after reset
// R9 - restore mode returns setpoint to pre-sequence steady value
// R10 - hold-last mode keeps the final sequence value afterwards
// R11 - trigger from one selected source: key, input pin or remote
// R12 - run the trapezoid repeat-count times, 1 to 2**24, default 1
// R13 - continuous bit, set at reset, repeats without end
// R14 - setpoint changes are ignored while a sequence runs
// R15 - run request starts; stop or run/stop toggle aborts
// R16 - host programs unbounded repeat via the continuous bit
// R17 - host sets sequence mode and enables output before trigger
// R18 - host sets the key or immediate source for key triggering
// R19 - ramps are linear in time; zero-length phases are skipped
// R20 - triggers ignored while running; end option also on abort
module tss_top import tss_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYC // clocks per interval step
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic reset_n, // async reset, low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata_ff, // read data
  output logic avs_waitrequest_ff, // stall, high until answer
  input wire tss_keys_t keys_i, // asynchronous key and trigger pins
  input wire tss_set_req_t local_req, // front panel setpoint change
  output logic [LVL_W-1:0] volt_sp_ff, // voltage setpoint
  output logic [LVL_W-1:0] curr_sp_ff, // current setpoint
  output logic output_on_ff, // output enable
  output logic running_ff // sequence active
);
  tss_keys_t sync1_ff, sync2_ff, sync3_ff;
  tss_keys_t edge_k;
  logic type_ff, hold_ff, cont_ff, mode_ff;
  tss_src_t src_ff;
  logic [LVL_W-1:0] start_ff, peak_ff, dcv_ff, dci_ff;
  logic [TIM_W-1:0] tim_ff [NPH];
  logic [REP_W-1:0] rep_ff, cnt_ff, rep_eff;
  tss_st_t state_ff, nxt_state;
  logic [31:0] pre_ff;
  logic [TIM_W-1:0] el_ff, ph_len;
  logic tick, ph_done, wr_go, rd_go, rmt_run, rmt_stop;
  logic trig, accept, abort, last_rep, fin, idle, ramp_load;
  logic [LVL_W-1:0] seq_lvl, ramp_lvl, ramp_from, ramp_to;
  logic [LVL_W-1:0] nxt_dcv, nxt_dci;
  logic [31:0] rd_val;

  // two flops before any logic reads the pins, third for edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= keys_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  assign edge_k = sync2_ff & ~sync3_ff;

  // bus: one wait state, write lands at the edge waitrequest is low
  assign wr_go = avs_write && !avs_waitrequest_ff;
  assign rd_go = avs_read && avs_waitrequest_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= '0;
    end else begin
      avs_waitrequest_ff <= !((avs_read || avs_write) &&
                              avs_waitrequest_ff);
      if (rd_go) begin
        avs_readdata_ff <= rd_val;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = '0;
    unique case (avs_address)
      A_CTRL: begin
        rd_val[B_TYPE] = type_ff;
        rd_val[B_HOLD] = hold_ff;
        rd_val[B_CONT] = cont_ff;
        rd_val[B_SRC +: 2] = src_ff;
        rd_val[B_MODE] = mode_ff;
        rd_val[B_OUT] = output_on_ff;
      end
      A_STAT: begin
        rd_val[2:0] = state_ff;
        rd_val[B_BUSY] = running_ff;
      end
      A_START: rd_val[LVL_W-1:0] = start_ff;
      A_PEAK: rd_val[LVL_W-1:0] = peak_ff;
      A_REP: rd_val[REP_W-1:0] = rep_ff;
      A_DCV: rd_val[LVL_W-1:0] = dcv_ff;
      A_DCI: rd_val[LVL_W-1:0] = dci_ff;
      default: begin
        for (int i = 0; i < NPH; i++) begin
          if (avs_address == A_TIM0 + 8'(i * A_STEP)) begin
            rd_val[TIM_W-1:0] = tim_ff[i];
          end
        end
      end
    endcase
  end

  // run and stop bits of the control word are command pulses
  assign rmt_run = wr_go && avs_address == A_CTRL && avs_writedata[B_RUN];
  assign rmt_stop = wr_go && avs_address == A_CTRL &&
                    avs_writedata[B_STOP];

  // configuration is frozen while running so the shape stays consistent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      type_ff <= 1'b0;
      hold_ff <= 1'b0;
      cont_ff <= CONT_RST;
      src_ff <= SRC_RMT;
      mode_ff <= 1'b0;
      output_on_ff <= 1'b0;
      start_ff <= '0;
      peak_ff <= '0;
      rep_ff <= REP_RST;
    end else if (wr_go && idle) begin
      if (avs_address == A_CTRL) begin
        type_ff <= avs_writedata[B_TYPE]; // R8
        hold_ff <= avs_writedata[B_HOLD];
        cont_ff <= avs_writedata[B_CONT];
        src_ff <= tss_src_t'(avs_writedata[B_SRC +: 2]);
        mode_ff <= avs_writedata[B_MODE];
        output_on_ff <= avs_writedata[B_OUT];
      end
      if (avs_address == A_START) begin
        start_ff <= avs_writedata[LVL_W-1:0]; // R6
      end
      if (avs_address == A_PEAK) begin
        peak_ff <= avs_writedata[LVL_W-1:0]; // R7
      end
      if (avs_address == A_REP) begin
        rep_ff <= avs_writedata[REP_W-1:0];
      end
    end
  end

  // one interval register per phase
  for (genvar g = 0; g < NPH; g++) begin : g_tim
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        tim_ff[g] <= '0;
      end else if (wr_go && idle &&
                   avs_address == A_TIM0 + 8'(g * A_STEP)) begin
        tim_ff[g] <= avs_writedata[TIM_W-1:0];
      end
    end
  end

  // trigger selection and abort
  assign idle = state_ff == ST_IDLE;
  always_comb begin
    unique case (src_ff)
      SRC_KEY: trig = edge_k.run || edge_k.runstop; // R11
      SRC_IO: trig = edge_k.dtrig; // R11
      SRC_RMT: trig = rmt_run; // R11
      default: trig = 1'b0;
    endcase
  end
  assign accept = idle && trig && mode_ff && output_on_ff; // R17 R20
  assign abort = !idle && (edge_k.stop || edge_k.runstop || rmt_stop); // R15

  // phase timing: a free step prescaler restarted on each phase entry
  assign tick = !idle && pre_ff == 32'(STEP_CYCLES - 1);
  assign ph_len = idle ? '0 : tim_ff[3'(state_ff - ST_DELAY)];
  assign ph_done = !idle && el_ff >= ph_len; // R19
  assign rep_eff = (rep_ff == '0) ? REP_RST : rep_ff;
  assign last_rep = !cont_ff && (cnt_ff + 1'b1 >= rep_eff); // R12 R13
  assign fin = abort || (state_ff == ST_ENDH && ph_done && last_rep);

  always_comb begin
    nxt_state = state_ff;
    if (abort) begin
      nxt_state = ST_IDLE; // R15
    end else if (accept) begin
      nxt_state = ST_DELAY; // R1
    end else if (ph_done) begin
      unique case (state_ff)
        ST_DELAY: nxt_state = ST_RISE; // R2
        ST_RISE: nxt_state = ST_PEAK; // R3
        ST_PEAK: nxt_state = ST_FALL; // R4
        ST_FALL: nxt_state = ST_ENDH; // R5
        ST_ENDH: nxt_state = last_rep ? ST_IDLE : ST_RISE; // R12 R13
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      running_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      running_ff <= nxt_state != ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= '0;
      el_ff <= '0;
    end else if (nxt_state != state_ff || idle) begin
      pre_ff <= '0;
      el_ff <= '0;
    end else if (tick) begin
      pre_ff <= '0;
      el_ff <= el_ff + 1'b1;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // completed trapezoid count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (accept) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_ENDH && ph_done && !cont_ff) begin
      cnt_ff <= cnt_ff + 1'b1; // R12
    end
  end

  // ramps load on entry to the rise or fall phase
  assign ramp_load = nxt_state != state_ff &&
                     (nxt_state == ST_RISE || nxt_state == ST_FALL);
  assign ramp_from = (nxt_state == ST_RISE) ? start_ff : peak_ff;
  assign ramp_to = (nxt_state == ST_RISE) ? peak_ff : start_ff;

  tss_ramp u_ramp (
    .clk(clk),
    .reset_n(reset_n),
    .load(ramp_load),
    .tick(tick),
    .from_lvl(ramp_from),
    .to_lvl(ramp_to),
    .len((state_ff == ST_FALL) ? tim_ff[3] : tim_ff[1]), // R19
    .level_ff(ramp_lvl)
  );

  // sequence value per phase
  always_comb begin
    unique case (state_ff)
      ST_RISE, ST_FALL: seq_lvl = ramp_lvl; // R19
      ST_PEAK: seq_lvl = peak_ff; // R3 R7
      default: seq_lvl = start_ff; // R1 R5 R6
    endcase
  end

  // steady values: locked while running, take last value in hold mode
  always_comb begin
    nxt_dcv = dcv_ff;
    nxt_dci = dci_ff;
    if (!running_ff) begin
      if (local_req.valid && !local_req.is_curr) begin
        nxt_dcv = local_req.value;
      end
      if (local_req.valid && local_req.is_curr) begin
        nxt_dci = local_req.value;
      end
      if (wr_go && avs_address == A_DCV) begin
        nxt_dcv = avs_writedata[LVL_W-1:0];
      end
      if (wr_go && avs_address == A_DCI) begin
        nxt_dci = avs_writedata[LVL_W-1:0];
      end
    end else if (fin && hold_ff) begin
      if (type_ff) begin
        nxt_dci = seq_lvl; // R10
      end else begin
        nxt_dcv = seq_lvl; // R10
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dcv_ff <= '0;
      dci_ff <= '0;
    end else begin
      dcv_ff <= nxt_dcv; // R14
      dci_ff <= nxt_dci; // R14
    end
  end

  // drive the target from the sequence, the other from its steady value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      volt_sp_ff <= '0;
      curr_sp_ff <= '0;
    end else begin
      volt_sp_ff <= (running_ff && !fin && !type_ff) ? seq_lvl
                                                   : nxt_dcv; // R8 R9
      curr_sp_ff <= (running_ff && !fin && type_ff) ? seq_lvl
                                                  : nxt_dci; // R8 R9
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_start;
    idle && accept;
  endsequence
  sequence s_peak_in;
    state_ff == ST_RISE && !abort && ph_done;
  endsequence

  a_delay_start: assert property (s_start |=> state_ff == ST_DELAY) // R1
    else $error("trigger did not enter delay");
  a_rise_follow: assert property (state_ff == ST_DELAY && ph_done &&
      !abort |=> state_ff == ST_RISE ##1 ramp_lvl == start_ff) // R2
    else $error("rise did not follow delay");
  a_peak_level: assert property (s_peak_in |=> state_ff == ST_PEAK
      ##1 (running_ff && !type_ff && !abort) |-> volt_sp_ff == peak_ff) // R3
    else $error("peak level not driven");
  a_fall_follow: assert property (state_ff == ST_PEAK && ph_done &&
      !abort |=> state_ff == ST_FALL ##1 ramp_lvl == peak_ff) // R4
    else $error("fall did not follow peak");
  a_end_level: assert property (state_ff == ST_ENDH && !fin &&
      !type_ff |=> volt_sp_ff == start_ff) // R5
    else $error("end level wrong");
  a_type_route: assert property (running_ff && type_ff
      |=> volt_sp_ff == $past(nxt_dcv)) // R8
    else $error("non-target setpoint moved");
  a_restore_dc: assert property (fin && !hold_ff && !type_ff
      |=> volt_sp_ff == dcv_ff && dcv_ff == $past(dcv_ff)) // R9
    else $error("restore value wrong");
  a_hold_last: assert property (fin && hold_ff && !type_ff
      |=> volt_sp_ff == $past(seq_lvl)) // R10
    else $error("last value not held");
  a_src_only: assert property (idle && src_ff != SRC_RMT && rmt_run &&
      !(trig) |=> idle) // R11
    else $error("unselected source started run");
  a_repeat_end: assert property (state_ff == ST_ENDH && ph_done &&
      !abort && !cont_ff && cnt_ff + 1'b1 >= rep_eff |=> idle) // R12
    else $error("repeat count overrun");
  a_cont_loop: assert property (state_ff == ST_ENDH && ph_done &&
      !abort && cont_ff |=> state_ff == ST_RISE) // R13
    else $error("continuous run stopped");
  a_lock_dc: assert property (running_ff && !fin
      |=> $stable(dcv_ff) && $stable(dci_ff)) // R14
    else $error("setpoint changed while running");
  // a fresh trigger may follow an abort at once, so only the next cycle
  a_abort_stop: assert property (abort |=> idle && !running_ff) // R15
    else $error("abort ignored");
  a_skip_zero: assert property (!idle && !abort && ph_len == '0 &&
      state_ff != ST_ENDH |=> state_ff != $past(state_ff)) // R19
    else $error("zero phase not skipped");
  a_no_retrig: assert property (!idle && trig && !abort
      && !ph_done |=> state_ff == $past(state_ff)) // R20
    else $error("trigger restarted a run");
endmodule // tss_top
`default_nettype wire

// ### bench/tss_panel.sv
`timescale 1ns/1ns
`default_nettype none
module tss_panel import tss_pkg::*; #(
  parameter int HOLD = 6 // cycles a pin stays pressed
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, low
  input wire tss_keys_t press, // one-cycle press requests from bench
  output tss_keys_t pins // key and trigger pins to the sequencer
);
  logic [7:0] cnt_ff [4];
  // a press holds its pin high for HOLD cycles, longer than the
  // two-flop synchroniser needs; released pins fall to the pull-down level
  always @(posedge clk or negedge reset_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!reset_n)
        cnt_ff[i] <= 8'h00;
      else if (press[i])
        cnt_ff[i] <= 8'(HOLD);
      else if (cnt_ff[i] != 8'h00)
        cnt_ff[i] <= cnt_ff[i] - 8'h01;
    end
  end
  // pin levels follow the hold counters
  assign pins = {cnt_ff[3] != 8'h00, cnt_ff[2] != 8'h00,
                 cnt_ff[1] != 8'h00, cnt_ff[0] != 8'h00};
endmodule // tss_panel
`default_nettype wire

// ### bench/trapezoid_setpoint_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module trapezoid_setpoint_sequencer_bench import tss_pkg::*; ;
  localparam int SC = 8; // short step keeps every phase a few clocks
  localparam int LIMIT = 5000; // whole run needs well under this
  localparam logic [LVL_W-1:0] start_level = 16'h0200;
  localparam logic [LVL_W-1:0] peak_level = 16'h0208; // small slope
  localparam logic [LVL_W-1:0] dc_v = 16'h0100;
  localparam logic [LVL_W-1:0] dc_i = 16'h0050;
  int tim_a[5] = '{2, 2, 1, 2, 1}; // delay, rise, width, fall, end
  int tim_c[5] = '{0, 1, 0, 1, 0}; // zero phases must be skipped
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata_ff;
  logic avs_waitrequest_ff;
  tss_keys_t press = '0;
  tss_keys_t keys;
  tss_set_req_t local_req = '0;
  logic [LVL_W-1:0] volt_sp_ff;
  logic [LVL_W-1:0] curr_sp_ff;
  logic output_on_ff;
  logic running_ff;
  logic [LVL_W-1:0] prev_v = 16'h0;
  logic [LVL_W-1:0] prev_i = 16'h0;
  logic [31:0] rd;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int peaks_v = 0;
  int peaks_i = 0;
  int run_len = 0;

  // free-running clock
  always #5 clk = ~clk;

  tss_top #(.STEP_CYCLES(SC)) u_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
    .avs_waitrequest_ff(avs_waitrequest_ff), .keys_i(keys),
    .local_req(local_req), .volt_sp_ff(volt_sp_ff),
    .curr_sp_ff(curr_sp_ff), .output_on_ff(output_on_ff),
    .running_ff(running_ff));

  tss_panel u_panel (.clk(clk), .reset_n(reset_n), .press(press),
    .pins(keys));

  // plateau entries count trapezoids; a hang ends the run here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    prev_v <= volt_sp_ff;
    prev_i <= curr_sp_ff;
    if (volt_sp_ff === peak_level && prev_v !== peak_level)
      peaks_v <= peaks_v + 1;
    if (curr_sp_ff === peak_level && prev_i !== peak_level)
      peaks_i <= peaks_i + 1;
    if (running_ff === 1'b1)
      run_len <= run_len + 1;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest_ff !== 1'b0 && n < 50);
    rd = avs_readdata_ff;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      check("bus answer", 32'h1, 32'h0);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                      input string what);
    bus(1'b0, a, 32'h0);
    check(what, e, rd);
  endtask

  task automatic wait_run(input logic lvl, input int lim);
    int n = 0;
    @(negedge clk);
    while (running_ff !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("running", {31'h0, lvl}, {31'h0, running_ff});
  endtask

  task automatic push(input tss_keys_t k);
    @(posedge clk);
    press <= k;
    @(posedge clk);
    press <= '0;
  endtask

  task automatic set_local(input logic cur, input logic [LVL_W-1:0] v);
    @(posedge clk);
    local_req <= '{valid: 1'b1, is_curr: cur, value: v};
    @(posedge clk);
    local_req.valid <= 1'b0;
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rreg(A_CTRL, 32'h14, "ctrl reset");
    rreg(A_REP, 32'h1, "repeat reset");
    rreg(A_STAT, 32'h0, "stat reset");
    rreg(8'h30, 32'h0, "unmapped read");
    // remote trigger, restore, two trapezoids, lockout while running
    wreg(A_START, {16'h0, start_level});
    wreg(A_PEAK, {16'h0, peak_level});
    for (int i = 0; i < NPH; i++)
      wreg(A_TIM0 + 8'(4 * i), 32'(tim_a[i]));
    wreg(A_REP, 32'h2);
    set_local(1'b0, dc_v);
    repeat (3) @(negedge clk);
    check("idle local set", {16'h0, dc_v}, {16'h0, volt_sp_ff});
    wreg(A_CTRL, 32'h70);
    @(negedge clk);
    check("output on", 32'h1, {31'h0, output_on_ff});
    run_len = 0;
    peaks_v = 0;
    wreg(A_CTRL, 32'h170);
    wait_run(1'b1, 10);
    repeat (4) @(negedge clk);
    check("delay level", {16'h0, start_level}, {16'h0, volt_sp_ff});
    set_local(1'b0, 16'h0333);
    wreg(A_DCV, 32'h0444);
    wreg(A_CTRL, 32'h170);
    wait_run(1'b0, 400);
    check("trapezoids", 32'h2, 32'(peaks_v));
    check("run length", 32'h1, {31'h0, run_len >= SC * 14 &&
      run_len <= SC * 14 + 14});
    repeat (3) @(negedge clk);
    check("restore", {16'h0, dc_v}, {16'h0, volt_sp_ff});
    check("current untouched", 32'h0, {16'h0, curr_sp_ff});
    // key source, continuous, hold-last, abort by run/stop key
    wreg(A_CTRL, 32'h66);
    push(4'b0001);
    wreg(A_CTRL, 32'h166);
    repeat (10) @(negedge clk);
    check("wrong source", 32'h0, {31'h0, running_ff});
    peaks_v = 0;
    push(4'b1000);
    wait_run(1'b1, 20);
    for (int n = 0; n < 300 && peaks_v < 2; n++)
      @(negedge clk);
    check("continuous", 32'h2, 32'(peaks_v));
    push(4'b0010);
    wait_run(1'b0, 10);
    repeat (3) @(negedge clk);
    check("hold last", {16'h0, peak_level}, {16'h0, volt_sp_ff});
    // current target, input pin source, zero phases, single repeat
    wreg(A_DCI, {16'h0, dc_i});
    for (int i = 0; i < NPH; i++)
      wreg(A_TIM0 + 8'(4 * i), 32'(tim_c[i]));
    wreg(A_REP, 32'h1);
    wreg(A_CTRL, 32'h69);
    peaks_i = 0;
    push(4'b0001);
    wait_run(1'b1, 20);
    wait_run(1'b0, 100);
    check("current peak", 32'h1, 32'(peaks_i));
    repeat (3) @(negedge clk);
    check("current restore", {16'h0, dc_i}, {16'h0, curr_sp_ff});
    check("voltage kept", {16'h0, peak_level}, {16'h0, volt_sp_ff});
    // remote stop bit aborts a continuous run and restores
    wreg(A_CTRL, 32'h75);
    wreg(A_CTRL, 32'h175);
    wait_run(1'b1, 10);
    wreg(A_CTRL, 32'h275);
    wait_run(1'b0, 10);
    repeat (3) @(negedge clk);
    check("abort restore", {16'h0, dc_i}, {16'h0, curr_sp_ff});
    complete_run();
  end
endmodule // trapezoid_setpoint_sequencer_bench
`default_nettype wire
